// ===== src/addr_xlate.sv
// Two-wire bus address translator core logic
// Behaviour
// R01: Low enable or undervoltage clears and shuts down
// R02: Switches open at power-on
// R03: Connect only when enabled, configured, buses idle; upper pin high connects without the idle wait
// R04: On connection close switches, raise ready
// R05: Upper pin high forces pass-through mode
// R06: Pass-through aborts translation immediately
// R07: Shift translation bits while upstream clock low
// R08: Extra downstream data glitches while clock low allowed
// R09: Master avoids START or STOP inside bytes
// R10: START with bit one appears as STOP
// R11: START with bit zero passes unchanged
// R12: Stray START resets translation at next STOP
// R13: STOP in address byte aborts, STOP guaranteed
// R14: STOP with bit one: disconnect, delay, STOP, reconnect
// R15: Stuck upstream clock 30ms aborts translation
// R16: Ordinary transactions pass transparently
// R17: Downstream address is XOR with translation byte
// R18: Lower pin low four bits, upper pin three
// R19: Reload translation byte on every enable rise
// R20: Only address bits of first byte translated
// R21: Idle and stuck counters restart on transitions
`default_nettype none
module addr_xlate #(
	parameter int IDLE_CNT = addr_xlate_pkg::IDLE_CYCLES,
	parameter int STUCK_CNT = addr_xlate_pkg::STUCK_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic link_clk_i,
	input wire logic enable_i,
	input wire logic supply_undervoltage_lockout_i,
	input wire logic upper_xlate_cfg_pin_i,
	input wire logic [2:0] upper_xlate_val_i,
	input wire logic [3:0] lower_xlate_val_i,
	input wire logic upstream_clock_line_i,
	input wire logic upstream_data_line_i,
	input wire logic downstream_clock_line_i,
	input wire logic downstream_data_line_i,
	output logic downstream_data_line_o,
	output logic downstream_data_line_oe_o,
	output logic first_pass_switch_o,
	output logic second_pass_switch_o,
	output logic ready_o
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [5:0] link_cap_r;
	logic [5:0] sync1_r;
	logic [5:0] sync2_r;
	logic [5:0] pins_raw;
	assign pins_raw = {enable_i, supply_undervoltage_lockout_i, upper_xlate_cfg_pin_i,
		upstream_clock_line_i, upstream_data_line_i,
		downstream_clock_line_i & downstream_data_line_i};
	// Link side capture, then two flops into the system clock
	always_ff @(posedge link_clk_i) begin
		link_cap_r <= pins_raw;
	end
	always_ff @(posedge clk_sys_i) begin
		sync1_r <= link_cap_r;
		sync2_r <= sync1_r;
	end
	addr_xlate_pkg::bus_lines_s up;
	logic en_s, supply_undervoltage_lockout_s, pass_s, down_high_s;
	assign en_s = sync2_r[5];
	assign supply_undervoltage_lockout_s = sync2_r[4];
	assign pass_s = sync2_r[3];
	assign up = addr_xlate_pkg::bus_lines_s'(sync2_r[2:1]);
	assign down_high_s = sync2_r[0];

	// ----------------------------------------
	// Line history and bus events
	// ----------------------------------------
	addr_xlate_pkg::bus_lines_s prev_r;
	logic en_prev_r;
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			prev_r <= '1;
			en_prev_r <= 1'b0;
		end else begin
			prev_r <= up;
			en_prev_r <= en_s;
		end
	end
	logic start_ev, stop_ev, scl_fall, scl_edge, shut, en_rise;
	assign start_ev = up.clk && prev_r.clk && prev_r.dat && !up.dat;
	assign stop_ev = up.clk && prev_r.clk && !prev_r.dat && up.dat;
	assign scl_fall = prev_r.clk && !up.clk;
	assign scl_edge = prev_r.clk != up.clk;
	assign shut = !en_s || supply_undervoltage_lockout_s; // R01
	assign en_rise = en_s && !en_prev_r;

	// ----------------------------------------
	// Translation byte loading
	// ----------------------------------------
	logic [6:0] xlate_r;
	logic cfg_read_r;
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			xlate_r <= addr_xlate_pkg::XLATE_RST; // R02
			cfg_read_r <= 1'b0;
		end else if (shut) begin
			xlate_r <= addr_xlate_pkg::XLATE_RST; // R01
			cfg_read_r <= 1'b0;
		end else if (en_rise || !cfg_read_r) begin
			xlate_r <= {upper_xlate_val_i, lower_xlate_val_i}; // R18 R19
			cfg_read_r <= 1'b1;
		end
	end

	// ----------------------------------------
	// Idle and stuck counters
	// ----------------------------------------
	logic [31:0] idle_cnt_r;
	logic [31:0] stuck_cnt_r;
	logic all_high, idle_long, stuck;
	assign all_high = up.clk && up.dat && down_high_s;
	assign idle_long = idle_cnt_r > 32'(IDLE_CNT); // R03
	assign stuck = stuck_cnt_r > 32'(STUCK_CNT); // R15
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i || !all_high) begin
			idle_cnt_r <= '0; // R21
		end else if (!idle_long) begin
			idle_cnt_r <= idle_cnt_r + 32'h1;
		end
	end

	// ----------------------------------------
	// Connection and address byte tracking
	// ----------------------------------------
	addr_xlate_pkg::conn_state_e st_r, st_nxt;
	logic xl_act_r, xl_act_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [7:0] gap_r;
	logic idle_ok;
	assign idle_ok = stop_ev || idle_long; // R03
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i || !xl_act_r || scl_edge) begin
			stuck_cnt_r <= '0; // R21
		end else if (!stuck) begin
			stuck_cnt_r <= stuck_cnt_r + 32'h1;
		end
	end

	logic cur_bit;
	assign cur_bit = (bit_r < addr_xlate_pkg::ADDR_BITS) ? xlate_r[3'(6 - bit_r)] : 1'b0;

	always_comb begin
		st_nxt = st_r;
		xl_act_nxt = xl_act_r;
		bit_nxt = bit_r;
		case (st_r)
			addr_xlate_pkg::ST_OFF: begin
				xl_act_nxt = 1'b0;
				if (cfg_read_r) begin
					st_nxt = addr_xlate_pkg::ST_WAIT_IDLE;
				end
			end
			addr_xlate_pkg::ST_WAIT_IDLE: begin
				if (idle_ok || pass_s) begin
					st_nxt = addr_xlate_pkg::ST_READY; // R04 R05
				end
			end
			addr_xlate_pkg::ST_READY: begin
				if (pass_s || stuck) begin
					xl_act_nxt = 1'b0; // R06 R15
				end else if (start_ev) begin
					xl_act_nxt = 1'b1; // R12 R20
					// First clock fall after START opens bit 0
					bit_nxt = 4'hf;
				end else if (stop_ev && xl_act_r) begin
					xl_act_nxt = 1'b0; // R13
					if (cur_bit) begin
						st_nxt = addr_xlate_pkg::ST_STOP_LOW; // R14
					end
				end else if (xl_act_r && scl_fall) begin
					bit_nxt = bit_r + 4'h1; // R07
					if (bit_r == addr_xlate_pkg::ADDR_BITS) begin
						xl_act_nxt = 1'b0; // R20 R16
					end
				end
			end
			addr_xlate_pkg::ST_STOP_LOW: begin
				if (gap_r == 8'(addr_xlate_pkg::STOP_GAP_CYCLES)) begin
					st_nxt = addr_xlate_pkg::ST_STOP_HIGH;
				end
			end
			addr_xlate_pkg::ST_STOP_HIGH: begin
				if (gap_r == 8'(addr_xlate_pkg::STOP_GAP_CYCLES)) begin
					st_nxt = addr_xlate_pkg::ST_READY;
				end
			end
			default: st_nxt = addr_xlate_pkg::ST_OFF;
		endcase
		if (shut) begin
			st_nxt = addr_xlate_pkg::ST_OFF; // R01
			xl_act_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			st_r <= addr_xlate_pkg::ST_OFF; // R02
			xl_act_r <= 1'b0;
			bit_r <= 4'h0;
			gap_r <= 8'h00;
		end else begin
			st_r <= st_nxt;
			xl_act_r <= xl_act_nxt;
			bit_r <= bit_nxt;
			gap_r <= (st_nxt != st_r) ? 8'h00 : gap_r + 8'h01;
		end
	end

	// ----------------------------------------
	// Delayed translation bit (shift timing)
	// ----------------------------------------
	logic [7:0] dly_r;
	logic inv_r;
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i || scl_fall) begin
			dly_r <= 8'h00;
		end else if (dly_r != 8'hff) begin
			dly_r <= dly_r + 8'h01;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i || !xl_act_nxt || pass_s) begin
			inv_r <= 1'b0; // R06
		end else if (!up.clk && dly_r >= 8'(addr_xlate_pkg::SHIFT_DELAY_CYCLES)) begin
			inv_r <= cur_bit; // R07 R08 R17
		end
	end

	// ----------------------------------------
	// Outputs: switches, ready, data drive
	// ----------------------------------------
	logic conn, gen_stop, gen_low;
	assign conn = (st_r == addr_xlate_pkg::ST_READY);
	assign gen_low = (st_r == addr_xlate_pkg::ST_STOP_LOW);
	assign gen_stop = gen_low || (st_r == addr_xlate_pkg::ST_STOP_HIGH);
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			first_pass_switch_o <= 1'b0; // R02
			second_pass_switch_o <= 1'b0;
			ready_o <= 1'b0;
			downstream_data_line_o <= 1'b1;
			downstream_data_line_oe_o <= 1'b0;
		end else begin
			first_pass_switch_o <= conn; // R03 R04 R05 R14
			second_pass_switch_o <= conn && !gen_stop;
			ready_o <= conn; // R04
			downstream_data_line_o <= gen_stop ? !gen_low : (up.dat ^ inv_r); // R10 R11
			downstream_data_line_oe_o <= gen_stop || conn; // R14
		end
	end
endmodule
`default_nettype wire

// ===== src/addr_xlate_pkg.sv
// Package of constants and types for the address translator
`default_nettype none
package addr_xlate_pkg;
	localparam int CLK_SYS_HZ = 50000000;
	localparam int IDLE_TIME_US = 120;
	localparam int IDLE_CYCLES = (IDLE_TIME_US * (CLK_SYS_HZ / 1000000) + 0);
	localparam int STUCK_TIME_MS = 30;
	localparam int STUCK_CYCLES = STUCK_TIME_MS * (CLK_SYS_HZ / 1000);
	localparam int SHIFT_DELAY_NS = 100;
	localparam int SHIFT_DELAY_CYCLES = SHIFT_DELAY_NS / (1000000000 / CLK_SYS_HZ);
	localparam int STOP_GAP_CYCLES = 8;
	localparam int LOW_XLATE_W = 4;
	localparam int HIGH_XLATE_W = 3;
	localparam logic [6:0] XLATE_RST = 7'h00;
	localparam logic [3:0] ADDR_BITS = 4'h7;

	typedef struct packed {
		logic clk;
		logic dat;
	} bus_lines_s;

	typedef struct packed {
		logic first_on;
		logic second_on;
	} switches_s;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_WAIT_IDLE,
		ST_READY,
		ST_STOP_LOW,
		ST_STOP_HIGH
	} conn_state_e;
endpackage
`default_nettype wire

// ===== testbench/addr_xlate_checker.sv
// Port assertions for the address translator
`default_nettype none
module addr_xlate_checker #(
	parameter int STUCK_CNT = 500
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic enable_i,
	input wire logic supply_undervoltage_lockout_i,
	input wire logic upper_xlate_cfg_pin_i,
	input wire logic upstream_clock_line_i,
	input wire logic upstream_data_line_i,
	input wire logic downstream_data_line_o,
	input wire logic downstream_data_line_oe_o,
	input wire logic first_pass_switch_o,
	input wire logic second_pass_switch_o,
	input wire logic ready_o
);
	// ----------
	// Helper logic
	// ----------
	int cnt_r;
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i || $changed(upstream_clock_line_i))
			cnt_r <= 0;
		else if (cnt_r < STUCK_CNT + 9)
			cnt_r <= cnt_r + 1;
	end
	// ----------
	// Assertions
	// ----------
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	sequence s_off;
		!enable_i [*5];
	endsequence
	sequence s_stuck;
		(cnt_r > STUCK_CNT + 8 && $stable(upstream_data_line_i)) [*4];
	endsequence
	a_en_shut: assert property (s_off |-> !ready_o && !first_pass_switch_o
		&& !downstream_data_line_oe_o) else $error("outputs active while disabled");
	a_uv_shut: assert property (supply_undervoltage_lockout_i [*5]
		|-> !second_pass_switch_o && !ready_o) else $error("outputs active in undervoltage");
	a_rst_open: assert property (disable iff (1'b0) !nrst_i |=> !ready_o
		&& !first_pass_switch_o && !second_pass_switch_o) else $error("switch closed in reset");
	a_ready_sw: assert property ($rose(ready_o)
		|-> first_pass_switch_o && second_pass_switch_o) else $error("ready without switches");
	a_conn_en: assert property ($rose(first_pass_switch_o)
		|-> $past(enable_i, 2) && !$past(supply_undervoltage_lockout_i, 2))
		else $error("connected while disabled");
	a_idle_conn: assert property ($rose(first_pass_switch_o)
		|-> $past(upstream_clock_line_i && upstream_data_line_i)) else $error("busy connect");
	a_pass_hold: assert property (enable_i && !supply_undervoltage_lockout_i
		&& upper_xlate_cfg_pin_i && first_pass_switch_o |=> first_pass_switch_o)
		else $error("switch opened in pass-through");
	a_stuck_free: assert property (s_stuck |-> !downstream_data_line_oe_o
		|| downstream_data_line_o == upstream_data_line_i) else $error("stuck clock kept xor");
endmodule
bind addr_xlate addr_xlate_checker #(.STUCK_CNT(STUCK_CNT)) u_addr_xlate_checker (.*);
`default_nettype wire

// ===== testbench/i2c_partner.sv
// Upstream master and downstream slave model
`default_nettype none
module i2c_partner (
	input wire logic lclk_i,
	input wire logic dscl_i,
	input wire logic dsda_i,
	output logic scl_o,
	output logic sda_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] rx;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		rx = 9'h000;
	end
	// Slave samples data on clock rise
	always @(posedge dscl_i) rx <= {rx[7:0], dsda_i};
	task q;
		repeat (20) @(posedge lclk_i);
	endtask
	task start;
		sda_o = 1'b0;
		q();
		scl_o = 1'b0;
		q();
	endtask
	task stop;
		sda_o = 1'b0;
		q();
		scl_o = 1'b1;
		q();
		sda_o = 1'b1;
		q();
	endtask
	// Whole byte plus released ack, no mid-byte conditions
	task byte_tx(input logic [7:0] b);
		for (int i = 8; i >= 0; i--) begin
			sda_o = (i > 0) ? b[i-1] : 1'b1;
			q();
			scl_o = 1'b1;
			q();
			q();
			scl_o = 1'b0;
			q();
		end
	endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking testbench for the address translator
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STUCK_CNT = 500;
	logic clk_sys_i, nrst_i, link_clk_i, enable_i, supply_undervoltage_lockout_i;
	logic upper_xlate_cfg_pin_i;
	logic [2:0] upper_xlate_val_i;
	logic [3:0] lower_xlate_val_i;
	wire logic upstream_clock_line_i, upstream_data_line_i;
	wire logic downstream_clock_line_i, downstream_data_line_i;
	logic downstream_data_line_o, downstream_data_line_oe_o;
	logic first_pass_switch_o, second_pass_switch_o, ready_o;
	int error_cnt, check_count;
	logic [22:0] rows [3] = '{{3'h3, 4'h1, 8'h32, 8'h50}, {3'h0, 4'h3, 8'h32, 8'h34},
		{3'h7, 4'hf, 8'ha5, 8'h5b}};
	addr_xlate #(.IDLE_CNT(50), .STUCK_CNT(STUCK_CNT)) u_addr_xlate (.*);
	i2c_partner u_i2c_partner (.lclk_i(link_clk_i), .dscl_i(downstream_clock_line_i),
		.dsda_i(downstream_data_line_i), .scl_o(upstream_clock_line_i),
		.sda_o(upstream_data_line_i));
	assign downstream_clock_line_i = first_pass_switch_o ? upstream_clock_line_i : 1'b1;
	assign downstream_data_line_i = downstream_data_line_oe_o ? downstream_data_line_o
		: (second_pass_switch_o ? upstream_data_line_i : 1'b1);
	// ----------
	// Clocks, tasks, watchdog
	// ----------
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		link_clk_i = 1'b0;
		#3;
		forever #6 link_clk_i = ~link_clk_i;
	end
	task cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task conn;
		enable_i = 1'b0;
		cyc(8);
		enable_i = 1'b1;
		for (int i = 0; i < 300 && ready_o !== 1'b1; i++) cyc(1);
		chk({6'h00, ready_o, second_pass_switch_o}, 8'h03);
	endtask
	task finish_test;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#1ms;
		error_cnt++;
		finish_test();
	end
	// ----------
	// Main sequence
	// ----------
	initial begin
		error_cnt = 0;
		check_count = 0;
		nrst_i = 1'b0;
		enable_i = 1'b0;
		supply_undervoltage_lockout_i = 1'b0;
		upper_xlate_cfg_pin_i = 1'b0;
		upper_xlate_val_i = 3'h0;
		lower_xlate_val_i = 4'h0;
		cyc(2);
		chk({6'h00, ready_o, first_pass_switch_o}, 8'h00);
		nrst_i = 1'b1;
		for (int i = 0; i < 3; i++) begin
			{upper_xlate_val_i, lower_xlate_val_i} = rows[i][22:16];
			conn();
			u_i2c_partner.start();
			u_i2c_partner.byte_tx(rows[i][15:8]);
			chk(u_i2c_partner.rx[8:1], rows[i][7:0]);
			u_i2c_partner.byte_tx(8'h5a);
			chk(u_i2c_partner.rx[8:1], 8'h5a);
			u_i2c_partner.stop();
			$display("row %0d done", i);
		end
		u_i2c_partner.start();
		cyc(STUCK_CNT + 40);
		u_i2c_partner.byte_tx(8'h32);
		chk(u_i2c_partner.rx[8:1], 8'h32);
		u_i2c_partner.stop();
		$display("stuck clock done");
		upper_xlate_cfg_pin_i = 1'b1;
		cyc(4);
		u_i2c_partner.start();
		u_i2c_partner.byte_tx(8'h00);
		chk(u_i2c_partner.rx[8:1], 8'h00);
		u_i2c_partner.stop();
		upper_xlate_cfg_pin_i = 1'b0;
		$display("pass-through done");
		supply_undervoltage_lockout_i = 1'b1;
		cyc(8);
		chk({6'h00, ready_o, second_pass_switch_o}, 8'h00);
		supply_undervoltage_lockout_i = 1'b0;
		$display("undervoltage done");
		finish_test();
	end
endmodule
`default_nettype wire
